// ==== include/embi_pkg.sv ====
// Shared constants, types and helpers of the external memory bus interface
package embi_pkg;

   // ==========================================================================
   // Geometry
   // ==========================================================================
   localparam int NUM_BANKS     = 8;
   localparam int ADDR_W        = 25;   // Address pins, offset within a bank
   localparam int SYS_ADDR_W    = 28;   // Eight banks of 32 MB
   localparam int DATA_W        = 32;
   localparam int LANES         = 4;
   localparam int BANK_LSB      = 25;
   localparam int SIZE_BASE_LOG = 18;   // Size code 0 is 256 KB, code 7 is 32 MB
   localparam int SYNC_STAGES   = 3;

   // ==========================================================================
   // Reset values and settle limit
   // ==========================================================================
   localparam logic [3:0] SYNC_RST  = 4'hC;  // {hold_req_n, stretch_n, boot[1:0]}
   localparam logic [1:0] SETTLE_MAX = 2'h3;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [1:0] {
      W8   = 2'b00,
      W16  = 2'b01,
      W32  = 2'b10,
      WTST = 2'b11
   } embi_width_t;

   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_ACC  = 2'b01,
      S_END  = 2'b10,
      S_HOLD = 2'b11
   } embi_state_t;

   typedef struct packed {
      embi_width_t width;    // Ignored for bank 0, which follows the boot pins
      logic [3:0]  cycles;   // Strobe length in clocks, 0 acts as 1
      logic [2:0]  size;     // Region is 2^(18+size) bytes from bank start
   } embi_bank_cfg_t;

   typedef struct packed {
      logic                  we;
      logic [SYS_ADDR_W-1:0] addr;   // Byte address
      logic [DATA_W-1:0]     wdata;
      logic [LANES-1:0]      be;
   } embi_req_t;

   // ==========================================================================
   // Helpers
   // ==========================================================================
   // Reserved code behaves as a full-width bus
   function automatic embi_width_t embi_width_fix(input embi_width_t w);
      return (w == WTST) ? W32 : w;
   endfunction

   function automatic logic [ADDR_W-1:0] embi_pin_addr(input embi_width_t w,
                                                      input logic [ADDR_W-1:0] a);
      case (w)
         W8:      return a;
         W16:     return a >> 1;
         default: return a >> 2;
      endcase
   endfunction

   function automatic logic [LANES-1:0] embi_lanes(input embi_width_t w,
                                                  input logic [1:0] a,
                                                  input logic [LANES-1:0] be);
      case (w)
         W8:      return {3'h0, be[a]};
         W16:     return a[1] ? {2'h0, be[3:2]} : {2'h0, be[1:0]};
         default: return be;
      endcase
   endfunction

   function automatic logic [DATA_W-1:0] embi_wlane(input embi_width_t w,
                                                   input logic [1:0] a,
                                                   input logic [DATA_W-1:0] d);
      case (w)
         W8:      return {24'h0, d[8*a +: 8]};
         W16:     return a[1] ? {16'h0, d[31:16]} : {16'h0, d[15:0]};
         default: return d;
      endcase
   endfunction

   // Narrow read data replicated so every byte lands in its own lane
   function automatic logic [DATA_W-1:0] embi_rlane(input embi_width_t w,
                                                   input logic [DATA_W-1:0] d);
      case (w)
         W8:      return {4{d[7:0]}};
         W16:     return {2{d[15:0]}};
         default: return d;
      endcase
   endfunction

endpackage

// ==== rtl/embi_bank_decode.sv ====
// Bank select decoder: at most one select bit from address and bank sizes, none beyond the bank size
`timescale 1ns/100ps
`default_nettype none
module embi_bank_decode (
   input  wire logic [embi_pkg::SYS_ADDR_W-1:0]                   i_addr,
   input  wire embi_pkg::embi_bank_cfg_t [embi_pkg::NUM_BANKS-1:0] i_bank_cfg,
   output logic [embi_pkg::NUM_BANKS-1:0]                          o_sel
);
   import embi_pkg::*;

   logic [2:0]        bank;
   logic [ADDR_W-1:0] offs;
   logic [ADDR_W-1:0] limit_mask;

   // Offset must stay below the bank's programmed size; at most one bit set
   always_comb begin
      bank       = i_addr[SYS_ADDR_W-1:BANK_LSB];
      offs       = i_addr[ADDR_W-1:0];
      limit_mask = ~((ADDR_W'(1) << (SIZE_BASE_LOG + int'(i_bank_cfg[bank].size))) - ADDR_W'(1));
      o_sel      = '0;
      if ((offs & limit_mask) == '0) begin
         o_sel[bank] = 1'b1;
      end
   end

endmodule // embi_bank_decode
`default_nettype wire

// ==== rtl/embi_top.sv ====
// External memory bus interface: strobes, bank selects, lanes, wait and bus hold
//
// Summary of operation
// - Boot pins 00/01/10 pick bank0 8/16/32, 11 test.
// - Boot pins sampled as reset ends, then frozen; code catches them once the synchroniser has filled after release.
// - 25-bit address pins carry offset within bank.
// - Data pins sampled on reads, driven on writes.
// - Bus width 8/16/32 chooses the active data lanes.
// - Bank select low when address inside bank region.
// - Access cycles and bank size come from configuration.
// - Write strobe low marks a write cycle.
// - Read strobe low marks a read cycle.
// - Byte lane enables, separate write-only lane enables.
// - Hold request low asks to hand over bus.
// - Grant asserted only after bus already released.
// - Stretch input low keeps access from finishing.
`timescale 1ns/100ps
`default_nettype none
module embi_top (
   input  wire logic                                               i_clk,
   input  wire logic                                               i_arst_n,
   input  wire logic [1:0]                                         i_boot_width_mode_pins,
   input  wire embi_pkg::embi_bank_cfg_t [embi_pkg::NUM_BANKS-1:0] i_bank_cfg,
   input  wire logic                                               i_req_valid,
   input  wire embi_pkg::embi_req_t                                i_req,
   output logic                                                    o_req_ready,
   output logic                                                    o_rsp_valid,
   output logic [embi_pkg::DATA_W-1:0]                             o_rsp_rdata,
   output logic                                                    o_boot_done,
   output logic                                                    o_test_mode,
   output logic [embi_pkg::ADDR_W-1:0]                             o_addr,
   output logic                                                    o_addr_oe,
   input  wire logic [embi_pkg::DATA_W-1:0]                        i_data,
   output logic [embi_pkg::DATA_W-1:0]                             o_data,
   output logic                                                    o_data_oe,
   output logic [embi_pkg::NUM_BANKS-1:0]                          o_bank_select_n,
   output logic                                                    o_write_strobe_n,
   output logic                                                    o_read_strobe_n,
   output logic [embi_pkg::LANES-1:0]                              o_write_lane_en_n,
   output logic [embi_pkg::LANES-1:0]                              o_sram_lane_en_n,
   output logic                                                    o_ctrl_oe,
   input  wire logic                                               i_hold_request_n,
   output logic                                                    o_hold_grant_n,
   input  wire logic                                               i_cycle_stretch_n
);
   import embi_pkg::*;

   // ==========================================================================
   // Pin synchronisers
   // ==========================================================================
   logic [3:0] s1_q, s2_q, s3_q, filt_q, filt_d;
   logic [3:0] pins;
   logic       hold_s, stretch_s;

   assign pins = {i_hold_request_n, i_cycle_stretch_n, i_boot_width_mode_pins};

   // A change counts only once the second and third stage agree
   always_comb begin
      filt_d = filt_q;
      for (int i = 0; i < 4; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            filt_d[i] = s3_q[i];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s1_q   <= SYNC_RST;
         s2_q   <= SYNC_RST;
         s3_q   <= SYNC_RST;
         filt_q <= SYNC_RST;
      end else begin
         s1_q   <= pins;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
      end
   end

   assign hold_s    = !filt_q[3];
   assign stretch_s = !filt_q[2];

   // ==========================================================================
   // Boot strap capture
   // ==========================================================================
   // Flops cannot load a pin under reset, so the straps are caught once the
   // synchroniser has filled after release and two stages agree.
   logic [1:0]  settle_q, settle_d;
   logic        boot_done_q, boot_done_d;
   logic [1:0]  boot_mode_q, boot_mode_d;
   embi_width_t boot_width;

   always_comb begin
      settle_d    = settle_q;
      boot_done_d = boot_done_q;
      boot_mode_d = boot_mode_q;
      if (settle_q != SETTLE_MAX) begin
         settle_d = settle_q + 2'h1;
      end else if (!boot_done_q && s2_q[1:0] == s3_q[1:0]) begin
         boot_done_d = 1'b1;
         boot_mode_d = s3_q[1:0];
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         settle_q    <= 2'h0;
         boot_done_q <= 1'b0;
         boot_mode_q <= 2'h0;
      end else begin
         settle_q    <= settle_d;
         boot_done_q <= boot_done_d;
         boot_mode_q <= boot_mode_d;
      end
   end

   // Test pattern leaves bank 0 at full width
   assign boot_width  = embi_width_fix(embi_width_t'(boot_mode_q));
   assign o_boot_done = boot_done_q;
   assign o_test_mode = boot_done_q && (boot_mode_q == WTST);

   // ==========================================================================
   // Bank decode
   // ==========================================================================
   logic [NUM_BANKS-1:0] dec_sel;
   logic [2:0]           req_bank;
   embi_width_t          req_width;
   logic [3:0]           req_cycles;

   embi_bank_decode embi_bank_decode_i (
      .i_addr     (i_req.addr),
      .i_bank_cfg (i_bank_cfg),
      .o_sel      (dec_sel)
   );

   always_comb begin
      req_bank   = i_req.addr[SYS_ADDR_W-1:BANK_LSB];
      req_width  = (req_bank == 3'h0) ? boot_width : embi_width_fix(i_bank_cfg[req_bank].width);
      req_cycles = (i_bank_cfg[req_bank].cycles == 4'h0) ? 4'h1 : i_bank_cfg[req_bank].cycles;
   end

   // ==========================================================================
   // Access sequencer
   // ==========================================================================
   embi_state_t          state_q, state_d;
   logic [3:0]           cnt_q, cnt_d;
   logic [ADDR_W-1:0]    addr_q, addr_d;
   logic [DATA_W-1:0]    wdata_q, wdata_d, rdata_q, rdata_d;
   logic [NUM_BANKS-1:0] sel_q, sel_d;
   logic [LANES-1:0]     lane_q, lane_d;
   logic                 we_q, we_d, grant_q, grant_d;
   embi_width_t          width_q, width_d;
   logic                 accept, in_acc;

   assign o_req_ready = (state_q == S_IDLE) && boot_done_q && !hold_s;
   assign accept      = i_req_valid && o_req_ready;
   assign in_acc      = (state_q == S_ACC);

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      addr_d  = addr_q;
      wdata_d = wdata_q;
      rdata_d = rdata_q;
      sel_d   = sel_q;
      lane_d  = lane_q;
      we_d    = we_q;
      width_d = width_q;
      grant_d = 1'b0;
      case (state_q)
         S_IDLE: begin
            if (hold_s && boot_done_q) begin
               state_d = S_HOLD;
            end else if (accept) begin
               state_d = S_ACC;
               cnt_d   = req_cycles;
               addr_d  = embi_pin_addr(req_width, i_req.addr[ADDR_W-1:0]);
               wdata_d = embi_wlane(req_width, i_req.addr[1:0], i_req.wdata);
               lane_d  = embi_lanes(req_width, i_req.addr[1:0], i_req.be);
               sel_d   = dec_sel;
               we_d    = i_req.we;
               width_d = req_width;
            end
         end
         S_ACC: begin
            if (cnt_q > 4'h1) begin
               cnt_d = cnt_q - 4'h1;
            end else if (!stretch_s) begin
               state_d = S_END;
               if (!we_q) begin
                  rdata_d = embi_rlane(width_q, i_data);
               end
            end
         end
         S_END: begin
            state_d = S_IDLE;
         end
         S_HOLD: begin
            // Grant follows the float by a cycle and leaves before we drive
            grant_d = hold_s;
            if (!hold_s && !grant_q) begin
               state_d = S_IDLE;
            end
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_q <= S_IDLE;
         cnt_q   <= 4'h0;
         addr_q  <= '0;
         wdata_q <= '0;
         rdata_q <= '0;
         sel_q   <= '0;
         lane_q  <= '0;
         we_q    <= 1'b0;
         width_q <= W8;
         grant_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         addr_q  <= addr_d;
         wdata_q <= wdata_d;
         rdata_q <= rdata_d;
         sel_q   <= sel_d;
         lane_q  <= lane_d;
         we_q    <= we_d;
         width_q <= width_d;
         grant_q <= grant_d;
      end
   end

   // ==========================================================================
   // Pin drive
   // ==========================================================================
   assign o_addr            = addr_q;
   assign o_data            = wdata_q;
   assign o_addr_oe         = (state_q != S_HOLD);
   assign o_ctrl_oe         = (state_q != S_HOLD);
   // Data stays driven through the end cycle for hold time
   assign o_data_oe         = we_q && (in_acc || state_q == S_END);
   assign o_bank_select_n   = ~(sel_q & {NUM_BANKS{in_acc}});
   assign o_write_strobe_n  = !(in_acc && we_q);
   assign o_read_strobe_n   = !(in_acc && !we_q);
   assign o_sram_lane_en_n  = ~(lane_q & {LANES{in_acc}});
   assign o_write_lane_en_n = ~(lane_q & {LANES{in_acc && we_q}});
   assign o_hold_grant_n    = !grant_q;
   assign o_rsp_valid       = (state_q == S_END);
   assign o_rsp_rdata       = rdata_q;

   // ==========================================================================
   // Checks
   // ==========================================================================
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   property p_boot_w8;
      accept && req_bank == 3'h0 && boot_mode_q == 2'b00 |=> width_q == W8;
   endproperty
   a_boot_w8 : assert property (p_boot_w8) else $error("bank0 not 8-bit");

   property p_boot_w16;
      accept && req_bank == 3'h0 && boot_mode_q == 2'b01 |=> width_q == W16;
   endproperty
   a_boot_w16 : assert property (p_boot_w16) else $error("bank0 not 16-bit");

   property p_grant_float;
      !o_hold_grant_n |-> !o_addr_oe && !o_ctrl_oe && !o_data_oe;
   endproperty
   a_grant_float : assert property (p_grant_float) else $error("driving while granted");

   property p_grant_late;
      $fell(o_hold_grant_n) |-> $past(!o_ctrl_oe);
   endproperty
   a_grant_late : assert property (p_grant_late) else $error("grant before release");

   property p_hold_take;
      state_q == S_IDLE && hold_s && boot_done_q |=> state_q == S_HOLD ##1 !o_hold_grant_n;
   endproperty
   a_hold_take : assert property (p_hold_take) else $error("hold request not honoured");

   property p_stretch;
      in_acc && stretch_s |=> in_acc;
   endproperty
   a_stretch : assert property (p_stretch) else $error("access ended while stretched");

   property p_cycles;
      in_acc && cnt_q > 4'h1 |=> in_acc && cnt_q == $past(cnt_q) - 4'h1;
   endproperty
   a_cycles : assert property (p_cycles) else $error("access shorter than programmed");

   property p_one_sel;
      $onehot0(~o_bank_select_n);
   endproperty
   a_one_sel : assert property (p_one_sel) else $error("two bank selects low");

   property p_sel_match;
      accept |=> (~o_bank_select_n) == $past(dec_sel);
   endproperty
   a_sel_match : assert property (p_sel_match) else $error("wrong bank select");

   property p_write_pins;
      !o_write_strobe_n |-> o_read_strobe_n && o_data_oe && o_write_lane_en_n == o_sram_lane_en_n;
   endproperty
   a_write_pins : assert property (p_write_pins) else $error("bad write cycle pins");

   property p_read_pins;
      !o_read_strobe_n |-> !o_data_oe && (&o_write_lane_en_n);
   endproperty
   a_read_pins : assert property (p_read_pins) else $error("bad read cycle pins");

   property p_narrow_lanes;
      in_acc && width_q == W8 |-> o_sram_lane_en_n[3:1] == 3'h7;
   endproperty
   a_narrow_lanes : assert property (p_narrow_lanes) else $error("lane outside 8-bit bus");

endmodule // embi_top
`default_nettype wire

// ==== verif/embi_mem_model.sv ====
// Partner model: SRAM banks, wait source and alternate bus master
`timescale 1ns/100ps
`default_nettype none
module embi_mem_model (
   input  wire logic        i_clk,
   input  wire logic [24:0] i_addr,
   input  wire logic [7:0]  i_sel_n,
   input  wire logic        i_rd_n,
   input  wire logic        i_wr_n,
   input  wire logic [3:0]  i_wlane_n,
   input  wire logic [31:0] i_data,
   input  wire logic [4:0]  i_wait_cyc,
   input  wire logic        i_want_bus,
   output logic [31:0]      o_data,
   output logic             o_stretch_n,
   output logic             o_hold_req_n
);
   // =====================================================================
   // Storage and bus
   // =====================================================================
   logic [31:0] mem [0:511];
   logic [31:0] last;
   logic [2:0]  bank;
   logic [4:0]  wcnt;
   logic        stb_q;
   initial begin
      for (int i = 0; i < 512; i++)
         mem[i] = 32'h0;
      last = 32'h0;
      wcnt = 5'h0;
      stb_q = 1'b0;
   end
   always_comb begin
      bank = 3'h0;
      for (int b = 0; b < 8; b++)
         if (!i_sel_n[b]) bank = 3'(b);
   end
   // Released bus shows the inverse of the last value, never a stale copy
   assign o_data = (!i_rd_n && i_sel_n != 8'hFF) ? mem[{bank, i_addr[5:0]}] : ~last;
   always @(posedge i_clk) begin
      stb_q <= !(i_rd_n && i_wr_n);
      if (!(i_rd_n && i_wr_n) && !stb_q)
         wcnt <= i_wait_cyc;
      else if (wcnt != 5'h0)
         wcnt <= wcnt - 5'h1;
      if (!i_wr_n && i_sel_n != 8'hFF)
         for (int l = 0; l < 4; l++)
            if (!i_wlane_n[l]) mem[{bank, i_addr[5:0]}][8*l +: 8] <= i_data[8*l +: 8];
      if (!i_rd_n && i_sel_n != 8'hFF)
         last <= o_data;
   end
   assign o_stretch_n  = (wcnt == 5'h0);
   assign o_hold_req_n = !i_want_bus;
endmodule // embi_mem_model
`default_nettype wire

// ==== verif/ext_memory_bus_interface_tb.sv ====
// Self-checking testbench of the external memory bus interface
`timescale 1ns/100ps
`default_nettype none
module ext_memory_bus_interface_tb;
   import embi_pkg::*;
   // =====================================================================
   // Signals
   // =====================================================================
   logic clk, arst_n, req_valid, hold_want, ready, rsp_v, bdone, tmode, aoe, doe, coe, wr_n, rd_n, grant_n, str_n, hreq_n;
   logic [1:0]  boot;
   logic [4:0]  wait_cyc;
   logic [24:0] pin_addr, c_addr;
   logic [31:0] rdata, mem_data, pin_data, c_dat, rdat;
   logic [7:0]  sel_n, c_sel;
   logic [3:0]  wl_n, sl_n, c_wl, c_sl;
   logic [1:0]  c_rw;
   embi_req_t   req;
   embi_bank_cfg_t [NUM_BANKS-1:0] cfg;
   int error_cnt, n_compared, cyc, nstb, lat;

   embi_top embi_top_i (.i_clk(clk), .i_arst_n(arst_n), .i_boot_width_mode_pins(boot), .i_bank_cfg(cfg),
      .i_req_valid(req_valid), .i_req(req), .o_req_ready(ready), .o_rsp_valid(rsp_v), .o_rsp_rdata(rdata),
      .o_boot_done(bdone), .o_test_mode(tmode), .o_addr(pin_addr), .o_addr_oe(aoe), .i_data(mem_data),
      .o_data(pin_data), .o_data_oe(doe), .o_bank_select_n(sel_n), .o_write_strobe_n(wr_n),
      .o_read_strobe_n(rd_n), .o_write_lane_en_n(wl_n), .o_sram_lane_en_n(sl_n), .o_ctrl_oe(coe),
      .i_hold_request_n(hreq_n), .o_hold_grant_n(grant_n), .i_cycle_stretch_n(str_n));
   embi_mem_model embi_mem_model_i (.i_clk(clk), .i_addr(pin_addr), .i_sel_n(sel_n), .i_rd_n(rd_n),
      .i_wr_n(wr_n), .i_wlane_n(wl_n), .i_data(pin_data), .i_wait_cyc(wait_cyc), .i_want_bus(hold_want),
      .o_data(mem_data), .o_stretch_n(str_n), .o_hold_req_n(hreq_n));

   // =====================================================================
   // Helpers
   // =====================================================================
   task automatic chk(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("BAD t=%0t %s", $time, msg);
      end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic do_reset(input logic [1:0] s);
      int k;
      arst_n <= 1'b0;
      boot   <= s;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      k = 0;
      do begin @(negedge clk); k++; end while (bdone !== 1'b1 && k < 50);
      chk(bdone === 1'b1, "boot never done");
      @(posedge clk);
   endtask

   // One pin access; records what the pins show during the strobe
   task automatic acc(input logic we, input logic [27:0] a, input logic [31:0] d, input logic [3:0] be);
      int k;
      req       <= '{we: we, addr: a, wdata: d, be: be};
      req_valid <= 1'b1;
      k = 0;
      do begin @(negedge clk); k++; end while (ready !== 1'b1 && k < 200);
      @(posedge clk);
      req_valid <= 1'b0;
      nstb = 0;
      lat = 0;
      c_sel = 8'hFF;
      do begin
         @(negedge clk);
         lat++;
         if (rd_n === 1'b0 || wr_n === 1'b0) begin
            nstb++;
            c_addr = pin_addr;
            c_sel = sel_n;
            c_wl = wl_n;
            c_sl = sl_n;
            c_dat = pin_data;
            c_rw = {rd_n, wr_n};
         end
      end while (rsp_v !== 1'b1 && lat < 200);
      rdat = rdata;
      chk(rsp_v === 1'b1, "no response");
      @(posedge clk);
   endtask

   // =====================================================================
   // Scenarios
   // =====================================================================
   task automatic t_boot;
      logic [31:0] d, e, wd;
      logic [24:0] ea;
      logic [3:0]  el;
      for (int s = 0; s < 4; s++) begin
         do_reset(2'(s));
         chk(tmode === (s == 3), "test mode flag");
         d  = 32'h5AC3_96E1 + 32'h0101_0101 * s;
         ea = (s == 0) ? 25'h10 : (s == 1) ? 25'h08 : 25'h04;
         el = (s == 0) ? 4'hE : (s == 1) ? 4'hC : 4'h0;
         e  = (s == 0) ? {4{d[7:0]}} : (s == 1) ? {2{d[15:0]}} : d;
         wd = (s == 0) ? {24'h0, d[7:0]} : (s == 1) ? {16'h0, d[15:0]} : d;
         acc(1'b1, 28'h10, d, ~el);
         chk(c_addr === ea, "boot bank address shift");
         chk(c_wl === el && c_sl === el && c_rw === 2'b10, "write lanes or strobes");
         chk(c_dat === wd, "write data lanes");
         chk(c_sel === 8'hFE, "bank zero select");
         acc(1'b0, 28'h10, 32'h0, ~el);
         chk(rdat === e, "read data replication");
         chk(c_wl === 4'hF && c_sl === el && c_rw === 2'b01, "read lanes or strobes");
      end
      $display("test boot widths done");
   endtask

   task automatic t_select;
      cfg[3] <= '{width: W8, cycles: 4'h2, size: 3'h0};
      cfg[5] <= '{width: W16, cycles: 4'h1, size: 3'h7};
      boot   <= 2'h0;
      @(posedge clk);
      acc(1'b1, 28'h600_0100, 32'h0000_00C4, 4'h1);
      chk(c_sel === 8'hF7 && c_addr === 25'h100, "bank three select");
      chk(c_dat === 32'h0000_00C4 && nstb == 2, "bank three data");
      acc(1'b1, 28'h604_0000, 32'h0000_0033, 4'h1);
      chk(c_sel === 8'hFF && nstb == 2, "select beyond bank size");
      acc(1'b0, 28'hE00_0000, 32'h0, 4'hF);
      chk(c_sel === 8'h7F, "bank seven select");
      acc(1'b1, 28'h600_0103, 32'h5A00_0000, 4'h8);
      chk(c_sl === 4'hE && c_addr === 25'h103 && c_dat === 32'h0000_005A, "byte three on 8-bit bank");
      acc(1'b1, 28'hA00_0102, 32'hBEEF_0000, 4'hC);
      chk(c_sl === 4'hC && c_wl === 4'hC && c_addr === 25'h081, "upper half lanes on 16-bit bank");
      chk(c_dat === 32'h0000_BEEF, "upper half data on 16-bit bank");
      acc(1'b0, 28'hA00_0102, 32'h0, 4'hC);
      chk(rdat === 32'hBEEF_BEEF && c_sel === 8'hDF, "16-bit bank read");
      chk(tmode === 1'b1, "straps not frozen");
      $display("test bank selects done");
   endtask

   task automatic t_cycles;
      int n;
      for (int i = 0; i < 3; i++) begin
         n = (i == 0) ? 0 : (i == 1) ? 5 : 15;
         cfg[2].cycles <= 4'(n);
         @(posedge clk);
         acc(1'b0, 28'h400_0020, 32'h0, 4'hF);
         chk(nstb == ((n == 0) ? 1 : n) && lat == nstb + 1, "access cycle count");
      end
      wait_cyc      <= 5'd12;
      cfg[2].cycles <= 4'h8;
      @(posedge clk);
      acc(1'b0, 28'h400_0020, 32'h0, 4'hF);
      chk(nstb > 12 && nstb < 22, "wait did not stretch");
      wait_cyc <= 5'd0;
      $display("test cycles and wait done");
   endtask

   task automatic t_hold;
      int k;
      fork
         acc(1'b0, 28'h400_0040, 32'h0, 4'hF);
         begin repeat (2) @(posedge clk); hold_want <= 1'b1; end
      join
      chk(nstb == 8, "access cut short by hold");
      k = 0;
      do begin @(negedge clk); k++; end while (grant_n !== 1'b0 && k < 20);
      chk(grant_n === 1'b0, "no grant");
      repeat (10) begin
         chk(aoe === 1'b0 && doe === 1'b0 && coe === 1'b0 && ready === 1'b0, "pins driven in hold");
         @(negedge clk);
      end
      @(posedge clk);
      hold_want <= 1'b0;
      k = 0;
      do begin @(negedge clk); k++; end while (grant_n !== 1'b1 && k < 20);
      chk(grant_n === 1'b1 && coe === 1'b0, "grant release order");
      @(negedge clk);
      chk(coe === 1'b1 && aoe === 1'b1, "pins not resumed");
      @(posedge clk);
      $display("test bus hold done");
   endtask

   // =====================================================================
   // Clock, timeout and main sequence
   // =====================================================================
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         error_cnt++;
         print_verdict();
      end
   end

   initial begin
      arst_n = 1'b0;
      boot = 2'h2;
      req_valid = 1'b0;
      req = '0;
      hold_want = 1'b0;
      wait_cyc = 5'h0;
      error_cnt = 0;
      n_compared = 0;
      cyc = 0;
      for (int b = 0; b < NUM_BANKS; b++)
         cfg[b] = '{width: W32, cycles: 4'h1, size: 3'h7};
      @(posedge clk);
      t_boot();
      t_select();
      t_cycles();
      t_hold();
      print_verdict();
   end
endmodule // ext_memory_bus_interface_tb
`default_nettype wire
